// file: include/slice_ram_map.svh
// Offsets, field positions and widths of the slice memory block
`ifndef SLICE_RAM_MAP_SVH
`define SLICE_RAM_MAP_SVH

`define BUS_ADDR_W         8
`define BUS_DATA_W         32

`define CFG_OFFSET         8'h00
`define STATUS_OFFSET      8'h04

`define CFG_SHAPE_LSB      0
`define CFG_SHAPE_MSB      1
`define CFG_DUAL_BIT       2
`define CFG_SYNC_READ_BIT  3
`define CFG_SR_MODE_LSB    4
`define CFG_SR_MODE_MSB    6

`define STATUS_Q_LSB       0
`define STATUS_Q_MSB       7
`define STATUS_CLAMP_BIT   8
`define STATUS_DUAL_BIT    9

`define CELL_COUNT         8
`define CELL_DEPTH         16
`define CELL_ADDR_W        4
`define RAM_ADDR_W         7
`define RAM_DATA_W         8
`define DUAL_COPY_CELLS    4
`define DUAL_MAX_SHAPE     2'd2

`endif

// file: include/slice_ram_pkg.sv
// Types shared by the slice memory and its cells
`default_nettype none
`include "slice_ram_map.svh"

package slice_ram_pkg;

  typedef enum logic [2:0] {
    sr_none,
    sr_sync_set,
    sr_sync_reset,
    sr_sync_set_reset,
    sr_async_preset,
    sr_async_clear,
    sr_async_preset_clear
  } sr_mode_t;

  typedef struct packed {
    sr_mode_t   sr_mode;
    logic       sync_read;
    logic       dual;
    logic [1:0] shape;
  } cfg_t;

  typedef struct packed {
    logic [`BUS_ADDR_W-1:0] addr;
    logic [`BUS_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } bus_req_t;

  typedef struct packed {
    logic [`RAM_ADDR_W-1:0] write_address_inputs;
    logic [`RAM_ADDR_W-1:0] read_address_inputs;
    logic [`RAM_DATA_W-1:0] write_data;
    logic                   slice_set_reset_input;
  } ram_in_t;

  typedef struct packed {
    logic [`RAM_DATA_W-1:0] d;
    logic                   ce;
    logic                   set;
    logic                   reset;
    logic                   preset;
    logic                   clear;
  } reg_ctrl_t;

  typedef struct packed {
    logic [`CELL_DEPTH-1:0] bits;
  } cell_state_t;

endpackage : slice_ram_pkg

`default_nettype wire

// file: src/lut_ram_cell.sv
// One 16 x 1 lookup-table memory cell: clocked write, combinational read
`default_nettype none
`include "slice_ram_map.svh"

module lut_ram_cell
  import slice_ram_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    we,
  input  wire logic [`CELL_ADDR_W-1:0] waddr,
  input  wire logic                    wdata,
  input  wire logic [`CELL_ADDR_W-1:0] raddr,
  output logic                         rdata
);
  import slice_ram_pkg::*;

  cell_state_t state;
  cell_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (we)
    begin
      next_state.bits[waddr] = wdata;
    end
  end

  // Contents are not reset, like real lookup-table memory
  always_ff @(posedge clk)
  begin
    state <= next_state;
  end

  assign rdata = state.bits[raddr];

endmodule : lut_ram_cell

`default_nettype wire

// file: src/lut_distributed_ram_slice_register.sv
// Distributed lookup-table memory of one logic block with its slice registers
//
// The address map and the address-and-strobe port were left to the implementer.
`default_nettype none
`include "slice_ram_map.svh"

module lut_distributed_ram_slice_register
  import slice_ram_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire slice_ram_pkg::bus_req_t bus_req,
  output logic [`BUS_DATA_W-1:0]      bus_rdata,
  input  wire slice_ram_pkg::ram_in_t ram_in,
  input  wire slice_ram_pkg::reg_ctrl_t reg_ctrl,
  output logic [`RAM_DATA_W-1:0]      port_a_data,
  output logic [`RAM_DATA_W/2-1:0]    port_b_data,
  output logic [`RAM_DATA_W-1:0]      reg_q
);
  import slice_ram_pkg::*;

  localparam int CELLS = `CELL_COUNT;

  typedef struct packed {
    cfg_t                   cfg;
    logic                   clamped;
    logic [`BUS_DATA_W-1:0] rdata;
  } main_state_t;

  main_state_t state;
  main_state_t next_state;

  // Log2 of the number of data lanes in one copy of the array
  function automatic logic [2:0] lane_log2(input cfg_t c);
    logic [2:0] top;
    top = c.dual ? 3'd2 : 3'd3;
    return top - {1'b0, c.shape};
  endfunction : lane_log2

  // Mask that keeps only the address bank bits the chosen depth uses
  function automatic logic [2:0] bank_mask(input cfg_t c);
    logic [2:0] one;
    one = 3'd1;
    return (one << c.shape) - 3'd1;
  endfunction : bank_mask

  // Configuration write with dual-port 128-deep folded back to 64 deep
  function automatic cfg_t cfg_from_word(input logic [`BUS_DATA_W-1:0] w);
    cfg_t c;
    c.shape     = w[`CFG_SHAPE_MSB:`CFG_SHAPE_LSB];
    c.dual      = w[`CFG_DUAL_BIT];
    c.sync_read = w[`CFG_SYNC_READ_BIT];
    c.sr_mode   = sr_mode_t'(w[`CFG_SR_MODE_MSB:`CFG_SR_MODE_LSB]);
    if (w[`CFG_SR_MODE_MSB:`CFG_SR_MODE_LSB] == 3'h7)
    begin
      c.sr_mode = sr_none;
    end
    if (c.dual && (c.shape > `DUAL_MAX_SHAPE))
    begin
      c.shape = `DUAL_MAX_SHAPE;
    end
    return c;
  endfunction : cfg_from_word

  logic [2:0]             lg;
  logic [2:0]             bmask;
  logic [2:0]             lane_mask;
  logic [2:0]             bank_w;
  logic [2:0]             bank_r;
  logic [CELLS-1:0]       cell_we;
  logic [CELLS-1:0]       cell_wdata;
  logic [CELLS-1:0]       cell_rdata;
  logic [`CELL_ADDR_W-1:0] cell_raddr [CELLS];
  logic [`RAM_DATA_W-1:0] read_a;
  logic [`RAM_DATA_W/2-1:0] read_b;
  logic [`RAM_DATA_W-1:0] read_word;
  logic [`RAM_DATA_W-1:0] reg_d;
  logic [`RAM_DATA_W-1:0] next_q;
  logic                   async_clear;
  logic                   async_preset;
  logic [`BUS_DATA_W-1:0] status_word;

  assign lg        = lane_log2(state.cfg);
  assign bmask     = bank_mask(state.cfg);
  assign lane_mask = (3'd1 << lg) - 3'd1;
  // Single-port: the one address bus picks the bank for write and read
  assign bank_w    = ram_in.write_address_inputs[`RAM_ADDR_W-1:`CELL_ADDR_W] & bmask;
  assign bank_r    = ram_in.read_address_inputs[`RAM_ADDR_W-1:`CELL_ADDR_W] & bmask;

  // Cell steering: each cell owns one lane of one depth bank in one copy
  generate
    for (genvar c = 0; c < CELLS; c++)
    begin : g_cell
      logic [2:0] idx;
      logic [2:0] lane;
      logic [2:0] bank;
      logic       second_copy;

      assign second_copy = state.cfg.dual && (c >= `DUAL_COPY_CELLS);
      assign idx         = state.cfg.dual ? {1'b0, 2'(c)} : 3'(c);
      assign lane        = idx & lane_mask;
      assign bank        = idx >> lg;

      // Both dual copies take the same write, so they hold the same data
      assign cell_we[c]    = ram_in.slice_set_reset_input && (bank == bank_w);
      assign cell_wdata[c] = ram_in.write_data[lane];
      // Second copy reads from the read-only port address
      assign cell_raddr[c] = second_copy
                           ? ram_in.read_address_inputs[`CELL_ADDR_W-1:0]
                           : ram_in.write_address_inputs[`CELL_ADDR_W-1:0];

      lut_ram_cell u_cell (
        .clk   (clk),
        .we    (cell_we[c]),
        .waddr (ram_in.write_address_inputs[`CELL_ADDR_W-1:0]),
        .wdata (cell_wdata[c]),
        .raddr (cell_raddr[c]),
        .rdata (cell_rdata[c])
      );
    end
  endgenerate

  // Read ports: lane b of the addressed bank, unused lanes read zero
  always_comb
  begin
    read_a = '0;
    read_b = '0;
    for (int b = 0; b < `RAM_DATA_W; b++)
    begin
      if (3'(b) <= lane_mask)
      begin
        read_a[b] = cell_rdata[(bank_w << lg) | 3'(b)];
      end
    end
    if (state.cfg.dual)
    begin
      for (int b = 0; b < `RAM_DATA_W / 2; b++)
      begin
        if (3'(b) <= lane_mask)
        begin
          read_b[b] = cell_rdata[3'd4 | (bank_r << lg) | 3'(b)];
        end
      end
    end
  end

  assign port_a_data = read_a;
  assign port_b_data = read_b;

  // In dual mode the registers hold port A in the low half, port B above
  assign read_word = state.cfg.dual ? {read_b, read_a[`RAM_DATA_W/2-1:0]} : read_a;
  assign reg_d     = state.cfg.sync_read ? read_word : reg_ctrl.d;

  // Synchronous set/reset behaviour of the slice registers
  always_comb
  begin
    next_q = reg_q;
    if (reg_ctrl.ce || state.cfg.sync_read)
    begin
      next_q = reg_d;
    end
    unique case (state.cfg.sr_mode)
      sr_none,
      sr_async_preset,
      sr_async_clear,
      sr_async_preset_clear:
      begin
      end
      sr_sync_set:
      begin
        if (reg_ctrl.set)
        begin
          next_q = '1;
        end
      end
      sr_sync_reset:
      begin
        if (reg_ctrl.reset)
        begin
          next_q = '0;
        end
      end
      sr_sync_set_reset:
      begin
        if (reg_ctrl.reset)
        begin
          next_q = '0;
        end
        else if (reg_ctrl.set)
        begin
          next_q = '1;
        end
      end
      default:
      begin
        next_q = reg_q;
      end
    endcase
  end

  assign async_clear  = reg_ctrl.clear
                      && ((state.cfg.sr_mode == sr_async_clear)
                       || (state.cfg.sr_mode == sr_async_preset_clear));
  assign async_preset = reg_ctrl.preset
                      && ((state.cfg.sr_mode == sr_async_preset)
                       || (state.cfg.sr_mode == sr_async_preset_clear));

  // Slice registers on the RAM clock; async controls act without it
  always_ff @(posedge clk or posedge async_clear or posedge async_preset)
  begin
    if (async_clear)
    begin
      reg_q <= '0;
    end
    else if (async_preset)
    begin
      reg_q <= '1;
    end
    else if (rst)
    begin
      reg_q <= '0;
    end
    else
    begin
      reg_q <= next_q;
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[`STATUS_Q_MSB:`STATUS_Q_LSB] = reg_q;
    status_word[`STATUS_CLAMP_BIT]            = state.clamped;
    status_word[`STATUS_DUAL_BIT]             = state.cfg.dual;
  end

  // Register port: writes take effect at the edge, read data one cycle later
  always_comb
  begin
    next_state       = state;
    next_state.rdata = '0;
    if (bus_req.wr && (bus_req.addr == `CFG_OFFSET))
    begin
      next_state.cfg     = cfg_from_word(bus_req.wdata);
      next_state.clamped = bus_req.wdata[`CFG_DUAL_BIT]
                         && (bus_req.wdata[`CFG_SHAPE_MSB:`CFG_SHAPE_LSB] > `DUAL_MAX_SHAPE);
    end
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `CFG_OFFSET:
        begin
          next_state.rdata[`CFG_SHAPE_MSB:`CFG_SHAPE_LSB]     = state.cfg.shape;
          next_state.rdata[`CFG_DUAL_BIT]                     = state.cfg.dual;
          next_state.rdata[`CFG_SYNC_READ_BIT]                = state.cfg.sync_read;
          next_state.rdata[`CFG_SR_MODE_MSB:`CFG_SR_MODE_LSB] = state.cfg.sr_mode;
        end
        `STATUS_OFFSET:
        begin
          next_state.rdata = status_word;
        end
        default:
        begin
          next_state.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state.cfg     <= '{sr_mode: sr_none, sync_read: 1'b0, dual: 1'b0, shape: 2'h0};
      state.clamped <= 1'b0;
      state.rdata   <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign bus_rdata = state.rdata;

endmodule : lut_distributed_ram_slice_register

`default_nettype wire

// file: test/lut_ram_slice_asserts.sv
// Port-level checks of the slice memory and its slice registers
`default_nettype none
`include "slice_ram_map.svh"

module lut_ram_slice_asserts
  import slice_ram_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire slice_ram_pkg::bus_req_t  bus_req,
  input  wire logic [`BUS_DATA_W-1:0]   bus_rdata,
  input  wire slice_ram_pkg::ram_in_t   ram_in,
  input  wire slice_ram_pkg::reg_ctrl_t reg_ctrl,
  input  wire logic [`RAM_DATA_W-1:0]   port_a_data,
  input  wire logic [`RAM_DATA_W/2-1:0] port_b_data,
  input  wire logic [`RAM_DATA_W-1:0]   reg_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import slice_ram_pkg::*;

  cfg_t       cfg;
  logic [6:0] wcfg;
  logic       we;
  logic       plain;
  logic       calm;

  assign wcfg = bus_req.wdata[6:0];
  assign we = ram_in.slice_set_reset_input;
  assign plain = cfg.shape == 2'h0 && !cfg.dual && !bus_req.wr;
  assign calm = cfg.sr_mode == sr_none && !bus_req.wr;

  // Shadow of the configuration, with the same clamping as the block
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg <= '0;
    else if (bus_req.wr && bus_req.addr == `CFG_OFFSET)
    begin
      cfg <= cfg_t'(wcfg);
      if (wcfg[6:4] == 3'h7)
        cfg.sr_mode <= sr_none;
      if (wcfg[2] && wcfg[1:0] == 2'h3)
        cfg.shape <= `DUAL_MAX_SHAPE;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_write;
    we && plain;
  endsequence
  sequence s_idle;
    !we && !bus_req.wr && $stable(ram_in.write_address_inputs);
  endsequence

  a_write_readback: assert property (
    s_write ##1 $stable(ram_in.write_address_inputs) |-> port_a_data == $past(ram_in.write_data))
    else $error("read after write differs");
  a_ram_hold: assert property (
    s_write ##1 s_idle ##1 s_idle |-> $stable(port_a_data))
    else $error("memory changed without write enable");
  a_sync_read: assert property (
    cfg.sync_read && !cfg.dual && calm |=> reg_q == $past(port_a_data))
    else $error("registered read missed memory word");
  a_load_d: assert property (
    !cfg.sync_read && reg_ctrl.ce && calm |=> reg_q == $past(reg_ctrl.d))
    else $error("slice register did not load");
  a_sync_rst_wins: assert property (
    cfg.sr_mode inside {sr_sync_reset, sr_sync_set_reset} && reg_ctrl.reset && !bus_req.wr
    |=> reg_q == 8'h00)
    else $error("synchronous reset lost");
  a_sync_set: assert property (
    cfg.sr_mode inside {sr_sync_set, sr_sync_set_reset} && reg_ctrl.set && !bus_req.wr
    && !(reg_ctrl.reset && cfg.sr_mode == sr_sync_set_reset) |=> reg_q == 8'hff)
    else $error("synchronous set lost");
  a_clear_wins: assert property (
    cfg.sr_mode inside {sr_async_clear, sr_async_preset_clear} && reg_ctrl.clear
    |-> reg_q == 8'h00)
    else $error("asynchronous clear lost");
  a_async_preset: assert property (
    cfg.sr_mode inside {sr_async_preset, sr_async_preset_clear} && reg_ctrl.preset
    && !(reg_ctrl.clear && cfg.sr_mode == sr_async_preset_clear) |-> reg_q == 8'hff)
    else $error("asynchronous preset lost");
endmodule : lut_ram_slice_asserts

bind lut_distributed_ram_slice_register lut_ram_slice_asserts u_asserts (
  .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .ram_in(ram_in),
  .reg_ctrl(reg_ctrl), .port_a_data(port_a_data), .port_b_data(port_b_data), .reg_q(reg_q));

`default_nettype wire

// file: test/ram_user_model.sv
// User logic that drives the memory's addresses, data and write enable
`default_nettype none
`include "slice_ram_map.svh"

module ram_user_model
  import slice_ram_pkg::*;
(
  input  wire logic                   clk,
  output var slice_ram_pkg::ram_in_t  ram_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial ram_in = '0;

  // Enable high for exactly one edge; data turns over once released
  task automatic write(input logic [6:0] wa, input logic [7:0] wd);
    @(posedge clk);
    ram_in.write_address_inputs <= wa;
    ram_in.write_data <= wd;
    ram_in.slice_set_reset_input <= 1'b1;
    @(posedge clk);
    ram_in.slice_set_reset_input <= 1'b0;
    ram_in.write_data <= ~wd;
  endtask : write

  task automatic aim(input logic [6:0] wa, input logic [6:0] ra);
    @(posedge clk);
    ram_in.write_address_inputs <= wa;
    ram_in.read_address_inputs <= ra;
  endtask : aim
endmodule : ram_user_model

`default_nettype wire

// file: test/tb_lut_distributed_ram_slice_register.sv
// Self-checking bench for the slice memory and its slice registers
`default_nettype none
`include "slice_ram_map.svh"

module tb_lut_distributed_ram_slice_register
  import slice_ram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  bus_req_t    bus_req = '0;
  reg_ctrl_t   reg_ctrl = '0;
  ram_in_t     ram_in;
  logic [31:0] bus_rdata;
  logic [7:0]  port_a_data;
  logic [7:0]  reg_q;
  logic [3:0]  port_b_data;
  logic [31:0] rd;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  lut_distributed_ram_slice_register dut (
    .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .ram_in(ram_in),
    .reg_ctrl(reg_ctrl), .port_a_data(port_a_data), .port_b_data(port_b_data), .reg_q(reg_q));
  ram_user_model u_user (.clk(clk), .ram_in(ram_in));

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask : bus_read

  // Preload 5a, select mode m, pulse {set,reset,preset,clear} for one cycle
  task automatic reg_case(input logic [2:0] m, input logic [3:0] srpc,
                          input logic [7:0] now_v, input logic [7:0] after_v);
    bus_write(`CFG_OFFSET, 32'h0);
    @(posedge clk);
    reg_ctrl <= '{d: 8'h5a, ce: 1'b1, default: 1'b0};
    @(posedge clk);
    reg_ctrl.ce <= 1'b0;
    bus_write(`CFG_OFFSET, 32'({m, 4'h0}));
    @(posedge clk);
    {reg_ctrl.set, reg_ctrl.reset, reg_ctrl.preset, reg_ctrl.clear} <= srpc;
    @(negedge clk);
    chk(32'(reg_q), 32'(now_v));
    @(posedge clk);
    {reg_ctrl.set, reg_ctrl.reset, reg_ctrl.preset, reg_ctrl.clear} <= 4'h0;
    @(negedge clk);
    chk(32'(reg_q), 32'(after_v));
  endtask : reg_case

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus_write(`CFG_OFFSET, 32'h70);
    bus_read(`CFG_OFFSET, rd);
    chk(rd, 32'h0);
    bus_write(`CFG_OFFSET, 32'h7);
    bus_read(`CFG_OFFSET, rd);
    chk(rd, 32'h6);
    bus_read(`STATUS_OFFSET, rd);
    chk(32'(rd[9:8]), 32'h3);
    bus_read(8'h08, rd);
    chk(rd, 32'h0);
    bus_write(`CFG_OFFSET, 32'h0);
    for (int i = 0; i < 16; i++)
      u_user.write(7'(i), 8'(i) ^ 8'ha5);
    for (int i = 0; i < 16; i++)
    begin
      u_user.aim(7'(i), 7'h0);
      @(negedge clk);
      chk(32'(port_a_data), 32'(8'(i) ^ 8'ha5));
    end
    // One write, then two idle edges with new data on the bus and the address held
    u_user.write(7'h5, 8'h3c);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(port_a_data), 32'h3c);
    for (int k = 0; k < 4; k++)
    begin
      bus_write(`CFG_OFFSET, 32'(k));
      u_user.write(7'h0, 8'h00);
      u_user.write(7'((16 << k) - 1), 8'hff);
      @(negedge clk);
      chk(32'(port_a_data), 32'((1 << (8 >> k)) - 1));
      u_user.aim(7'h0, 7'h0);
      @(negedge clk);
      chk(32'(port_a_data), 32'h0);
    end
    for (int k = 0; k < 3; k++)
    begin
      bus_write(`CFG_OFFSET, 32'(k) | 32'h4);
      u_user.write(7'h0, 8'h00);
      u_user.write(7'((16 << k) - 1), 8'hff);
      u_user.aim(7'h0, 7'((16 << k) - 1));
      @(negedge clk);
      chk(32'({port_b_data, port_a_data}), 32'(((1 << (4 >> k)) - 1) << 8));
    end
    reg_case(3'h0, 4'b1111, 8'h5a, 8'h5a);
    reg_case(3'h1, 4'b1000, 8'h5a, 8'hff);
    reg_case(3'h1, 4'b0100, 8'h5a, 8'h5a);
    reg_case(3'h2, 4'b0100, 8'h5a, 8'h00);
    reg_case(3'h2, 4'b1000, 8'h5a, 8'h5a);
    reg_case(3'h3, 4'b1100, 8'h5a, 8'h00);
    reg_case(3'h3, 4'b1000, 8'h5a, 8'hff);
    reg_case(3'h4, 4'b0010, 8'hff, 8'hff);
    reg_case(3'h4, 4'b0001, 8'h5a, 8'h5a);
    reg_case(3'h5, 4'b0001, 8'h00, 8'h00);
    reg_case(3'h5, 4'b0010, 8'h5a, 8'h5a);
    reg_case(3'h6, 4'b0011, 8'h00, 8'h00);
    reg_case(3'h6, 4'b0010, 8'hff, 8'hff);
    bus_write(`CFG_OFFSET, 32'h8);
    u_user.write(7'h3, 8'h96);
    // The write edge registers the word that stood before it
    @(negedge clk);
    chk(32'(reg_q), 32'ha6);
    @(negedge clk);
    chk(32'(reg_q), 32'h96);
    stop_test();
  end
endmodule : tb_lut_distributed_ram_slice_register

`default_nettype wire
